// ### logic/gyro_params.svh
// Constants for the rotation output register block
`ifndef GYRO_PARAMS_SVH
`define GYRO_PARAMS_SVH

// Register byte addresses, lower byte of each 16-bit word
`define RATE_X_LOW_ADDR 7'h04
`define RATE_X_HIGH_ADDR 7'h06
`define RATE_Y_LOW_ADDR 7'h08
`define RATE_Y_HIGH_ADDR 7'h0A
`define RATE_Z_LOW_ADDR 7'h0C
`define RATE_Z_HIGH_ADDR 7'h0E
`define ANGLE_STEP_X_ADDR 7'h24
`define ANGLE_STEP_Y_ADDR 7'h26
`define ANGLE_STEP_Z_ADDR 7'h28

// Sync mode field value that selects the internal sample clock
`define SYNC_MODE_INTERNAL 2'h0

// Sample clock timing
`define SYS_CLK_HZ 25000000
`define INT_SAMPLE_HZ 2048
`define INT_TICK_CYCLES (`SYS_CLK_HZ / `INT_SAMPLE_HZ)

// Divider: index of the last of its step cycles
`define DIV_LAST 6'h21

// Serial frame: index of the last bit
`define SPI_LAST_BIT 5'h0F

`endif

// ### logic/gyro_pkg.sv
// Types shared by the rotation output register block
package gyro_pkg;
   typedef logic [15:0] word_t;
   typedef logic [95:0] sample_t;
   typedef enum logic {PH_IDLE, PH_DIVIDE} phase_e;
endpackage

// ### logic/sample_fifo.sv
// Sample FIFO with registered head word
module sample_fifo #(
   parameter int WIDTH = 96,
   parameter int DEPTH = 32,
   parameter int AW = $clog2(DEPTH)
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   // All storage of the FIFO
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [AW:0] count;
      logic [WIDTH-1:0] head;
   } fifo_s;

   fifo_s st; // Registered state
   fifo_s next_st; // Next state

   // Pointer step with wrap, works for any depth
   function automatic logic [AW-1:0] bump(logic [AW-1:0] p);
      bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   assign in_ready = (st.count != (AW + 1)'(DEPTH));
   assign out_valid = (st.count != '0);
   assign out_data = st.head;

   // Head is re-read every cycle so it is ready without an extra pop cycle
   always_comb begin
      logic push;
      logic pop;
      logic [AW-1:0] rd_next;
      push = 1'b0;
      pop = 1'b0;
      rd_next = '0;
      next_st = st;
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      rd_next = pop ? bump(st.rd_ptr) : st.rd_ptr;
      if (push) begin
         next_st.mem[st.wr_ptr] = in_data;
         next_st.wr_ptr = bump(st.wr_ptr);
      end
      next_st.rd_ptr = rd_next;
      // Bypass when the word just written becomes the head
      if (push && (st.wr_ptr == rd_next)) begin
         next_st.head = in_data;
      end else begin
         next_st.head = st.mem[rd_next];
      end
      next_st.count = st.count + (AW + 1)'(push) - (AW + 1)'(pop);
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
endmodule // sample_fifo

// ### logic/gyro_rate_regs.sv
// Rotation output registers: rate words, angle steps and serial read port
// Function
// - High rate word: 16-bit signed, 0.005 dps/LSB
// - Zero rate reads as all zeros
// - Low rate word holds filter bit growth
// - High and low words form 32-bit rate
// - One angle step register per axis
// - Angle step LSB: scale*(decimation+1)/sample rate
// - Sync mode zero uses internal 2048 Hz
// - Low word at lower address, from 0x04
// - Two bytes per register, upper at +1
`include "gyro_params.svh"

module gyro_rate_regs #(
   parameter int TICK_CYCLES = `INT_TICK_CYCLES,
   parameter int FIFO_DEPTH = 32
) (
   input wire logic CLK_SYS,
   input wire logic ARST_N,
   input wire gyro_pkg::sample_t SAMPLE_DATA,
   input wire logic SAMPLE_VALID,
   output logic SAMPLE_READY,
   input wire logic [1:0] MISC_SYNC_MODE,
   input wire gyro_pkg::word_t DECIMATION_SETTING,
   input wire logic EXT_SYNC,
   input wire logic SPI_SCLK,
   input wire logic SPI_CS_N,
   input wire logic SPI_DIN,
   output logic SPI_DOUT,
   output logic SPI_DOUT_OE
);
   import gyro_pkg::*;

   // All state of the block
   typedef struct packed {
      phase_e phase;
      logic [15:0] tick_cnt;
      logic [2:0] ext_sh;
      logic ext_lvl;
      logic [2:0] sclk_sh;
      logic [2:0] cs_sh;
      logic [2:0] din_sh;
      logic sclk_lvl;
      logic cs_lvl;
      logic [15:0] shift_in;
      logic [4:0] bit_cnt;
      logic [15:0] shift_out;
      logic [6:0] rd_addr;
      logic [15:0] dec_cnt;
      logic [2:0][33:0] acc;
      logic [2:0][33:0] num;
      logic [2:0][17:0] rem;
      logic [2:0] neg;
      logic [16:0] divisor;
      logic [5:0] step;
      logic [2:0][31:0] rate_last;
      logic [2:0][31:0] rate_held;
      logic [2:0][15:0] angle;
   } state_s;

   state_s st; // Registered state
   state_s next_st; // Next state
   sample_t fifo_data; // Head sample, x in the low 32 bits
   logic fifo_valid; // Head sample present
   logic fifo_pop; // Take head sample
   logic tick; // Sample clock event
   logic start_div; // Decimation window closes
   logic commit; // All output words load this edge

   // One restoring divide step: returns new remainder and quotient bit
   function automatic logic [18:0] div_step(logic [17:0] r, logic b, logic [16:0] d);
      logic [17:0] sh;
      sh = {r[16:0], b};
      if (sh >= {1'b0, d}) begin
         div_step = {sh - {1'b0, d}, 1'b1};
      end else begin
         div_step = {sh, 1'b0};
      end
   endfunction

   // Register read decode; odd address returns the upper byte alone
   function automatic word_t read_word(logic [6:0] a, logic [2:0][31:0] r, logic [2:0][15:0] g);
      logic [6:0] w;
      word_t v;
      w = {a[6:1], 1'b0};
      if (w == `RATE_X_LOW_ADDR) begin
         v = r[0][15:0];
      end else if (w == `RATE_X_HIGH_ADDR) begin
         v = r[0][31:16];
      end else if (w == `RATE_Y_LOW_ADDR) begin
         v = r[1][15:0];
      end else if (w == `RATE_Y_HIGH_ADDR) begin
         v = r[1][31:16];
      end else if (w == `RATE_Z_LOW_ADDR) begin
         v = r[2][15:0];
      end else if (w == `RATE_Z_HIGH_ADDR) begin
         v = r[2][31:16];
      end else if (w == `ANGLE_STEP_X_ADDR) begin
         v = g[0];
      end else if (w == `ANGLE_STEP_Y_ADDR) begin
         v = g[1];
      end else if (w == `ANGLE_STEP_Z_ADDR) begin
         v = g[2];
      end else begin
         // Unmapped addresses read as zero
         v = 16'h0000;
      end
      read_word = a[0] ? {8'h00, v[15:8]} : v;
   endfunction

   // Filtered samples queue here until the sample clock takes them
   sample_fifo #(
      .WIDTH($bits(sample_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(CLK_SYS),
      .rst_n(ARST_N),
      .in_data(SAMPLE_DATA),
      .in_valid(SAMPLE_VALID),
      .in_ready(SAMPLE_READY),
      .out_data(fifo_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop)
   );

   assign SPI_DOUT = st.shift_out[15];
   assign SPI_DOUT_OE = !st.cs_lvl;

   // Next state: pin sync, sample clock, accumulate, divide, serial port
   always_comb begin
      logic [33:0] sum;
      logic [18:0] ds;
      logic sclk_rise;
      logic sclk_fall;
      logic ext_rise;
      sum = '0;
      ds = '0;
      sclk_rise = 1'b0;
      sclk_fall = 1'b0;
      ext_rise = 1'b0;
      next_st = st;
      tick = 1'b0;
      start_div = 1'b0;
      commit = 1'b0;
      // Three-stage synchronisers; a level counts once stages two and three agree
      next_st.ext_sh = {st.ext_sh[1:0], EXT_SYNC};
      next_st.sclk_sh = {st.sclk_sh[1:0], SPI_SCLK};
      next_st.cs_sh = {st.cs_sh[1:0], SPI_CS_N};
      next_st.din_sh = {st.din_sh[1:0], SPI_DIN};
      if (st.ext_sh[1] == st.ext_sh[2]) begin
         next_st.ext_lvl = st.ext_sh[2];
      end
      if (st.sclk_sh[1] == st.sclk_sh[2]) begin
         next_st.sclk_lvl = st.sclk_sh[2];
      end
      if (st.cs_sh[1] == st.cs_sh[2]) begin
         next_st.cs_lvl = st.cs_sh[2];
      end
      ext_rise = next_st.ext_lvl && !st.ext_lvl;
      sclk_rise = next_st.sclk_lvl && !st.sclk_lvl;
      sclk_fall = !next_st.sclk_lvl && st.sclk_lvl;
      // Sample clock: internal divider or external edge
      if (MISC_SYNC_MODE == `SYNC_MODE_INTERNAL) begin
         if (st.tick_cnt == 16'(TICK_CYCLES - 1)) begin
            tick = 1'b1;
            next_st.tick_cnt = '0;
         end else begin
            next_st.tick_cnt = st.tick_cnt + 16'h0001;
         end
      end else begin
         tick = ext_rise;
         next_st.tick_cnt = '0;
      end
      // A tick during a divide is dropped; the divide is far shorter than a period
      fifo_pop = tick && (st.phase == PH_IDLE);
      case (st.phase)
         PH_IDLE: begin
            if (fifo_pop && fifo_valid) begin
               start_div = (st.dec_cnt >= DECIMATION_SETTING);
               for (int a = 0; a < 3; a++) begin
                  next_st.rate_last[a] = fifo_data[a*32 +: 32];
                  // Angle is the window sum of high rate words divided by the sample count, in rate LSBs
                  sum = st.acc[a] + {{18{fifo_data[a*32+31]}}, fifo_data[a*32+16 +: 16]};
                  if (start_div) begin
                     next_st.neg[a] = sum[33];
                     next_st.num[a] = sum[33] ? (34'h0 - sum) : sum;
                     next_st.rem[a] = '0;
                     next_st.acc[a] = '0;
                  end else begin
                     next_st.acc[a] = sum;
                  end
               end
               if (start_div) begin
                  // Divide by samples really summed, in case decimation changed
                  next_st.divisor = {1'b0, st.dec_cnt} + 17'h00001;
                  next_st.dec_cnt = '0;
                  next_st.step = '0;
                  next_st.phase = PH_DIVIDE;
               end else begin
                  next_st.dec_cnt = st.dec_cnt + 16'h0001;
               end
            end
         end
         PH_DIVIDE: begin
            for (int a = 0; a < 3; a++) begin
               ds = div_step(st.rem[a], st.num[a][33], st.divisor);
               next_st.rem[a] = ds[18:1];
               next_st.num[a] = {st.num[a][32:0], ds[0]};
            end
            next_st.step = st.step + 6'h01;
            if (st.step == `DIV_LAST) begin
               // Every output word loads on the same edge
               commit = 1'b1;
               next_st.rate_held = st.rate_last;
               for (int a = 0; a < 3; a++) begin
                  // Two's complement around zero
                  next_st.angle[a] = st.neg[a] ? (16'h0000 - next_st.num[a][15:0])
                                               : next_st.num[a][15:0];
               end
               next_st.phase = PH_IDLE;
            end
         end
         default: begin
            next_st.phase = PH_IDLE;
         end
      endcase
      // Serial port, clock idles high, data out on falls and in on rises
      if (next_st.cs_lvl) begin
         next_st.bit_cnt = '0;
      end else if (st.cs_lvl) begin
         // Answer to the address of the previous frame
         next_st.shift_out = read_word(st.rd_addr, st.rate_held, st.angle);
         next_st.bit_cnt = '0;
      end else if (sclk_rise) begin
         next_st.shift_in = {st.shift_in[14:0], st.din_sh[2]};
         next_st.bit_cnt = st.bit_cnt + 5'h01;
         // Only read frames set the address; writes find nothing here
         if ((st.bit_cnt == `SPI_LAST_BIT) && !st.shift_in[14]) begin
            next_st.rd_addr = st.shift_in[13:7];
         end
      end else if (sclk_fall && (st.bit_cnt != '0)) begin
         next_st.shift_out = {st.shift_out[14:0], 1'b0};
      end
   end

   // State register
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         st <= '{phase: PH_IDLE, ext_sh: 3'h0, sclk_sh: 3'h7, cs_sh: 3'h7, sclk_lvl: 1'b1,
                 cs_lvl: 1'b1, default: '0};
      end else begin
         st <= next_st;
      end
   end

   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!ARST_N);

   // High x word after commit is the sample's upper half
   property p_high_x;
      commit |=> (read_word(`RATE_X_HIGH_ADDR, st.rate_held, st.angle) == $past(st.rate_last[0][31:16]));
   endproperty
   a_high_x: assert property (p_high_x) else $error("x high word wrong after commit");

   // Low z word after commit carries the low half
   property p_low_z;
      commit |=> (read_word(`RATE_Z_LOW_ADDR, st.rate_held, st.angle) == $past(st.rate_last[2][15:0]));
   endproperty
   a_low_z: assert property (p_low_z) else $error("z low word wrong after commit");

   // High and low y words rebuild the 32-bit rate
   property p_pair_y;
      commit |=> ({read_word(`RATE_Y_HIGH_ADDR, st.rate_held, st.angle),
                   read_word(`RATE_Y_LOW_ADDR, st.rate_held, st.angle)} == $past(st.rate_last[1]));
   endproperty
   a_pair_y: assert property (p_pair_y) else $error("y word pair does not form the rate");

   // No decimation: angle step equals the high rate word 35 cycles on
   property p_angle_unit;
      (start_div && (st.dec_cnt == 16'h0000)) |-> ##35 (st.angle[0] == st.rate_last[0][31:16]);
   endproperty
   a_angle_unit: assert property (p_angle_unit) else $error("angle step not rate at unit window");

   // Divide always finishes in 34 cycles
   property p_div_len;
      start_div |=> (st.phase == PH_DIVIDE) [*8] ##26 commit;
   endproperty
   a_div_len: assert property (p_div_len) else $error("divide length wrong");

   // Internal mode ticks only at the end of the count
   property p_int_tick;
      (tick && (MISC_SYNC_MODE == `SYNC_MODE_INTERNAL)) |-> (st.tick_cnt == 16'(TICK_CYCLES - 1));
   endproperty
   a_int_tick: assert property (p_int_tick) else $error("internal tick off period");

   // Frame start loads the x low word for address 0x04
   property p_map_low;
      ($fell(st.cs_lvl) && (st.rd_addr == `RATE_X_LOW_ADDR)) |-> (st.shift_out == $past(st.rate_held[0][15:0]));
   endproperty
   a_map_low: assert property (p_map_low) else $error("x low word not at its address");

   // Odd address answers with a zero upper byte
   property p_odd_byte;
      ($fell(st.cs_lvl) && st.rd_addr[0]) |-> (st.shift_out[15:8] == 8'h00);
   endproperty
   a_odd_byte: assert property (p_odd_byte) else $error("odd address upper byte not zero");

   // Output words change only on the commit edge
   property p_together;
      !commit |=> ($stable(st.rate_held) && $stable(st.angle));
   endproperty
   a_together: assert property (p_together) else $error("output words changed outside commit");
endmodule // gyro_rate_regs

// ### bench/spi_host_model.sv
// Host side serial master model that reads the rotation output registers
module spi_host_model (
   input wire logic clk,
   output logic sclk,
   output logic cs_n,
   output logic din,
   input wire logic dout,
   input wire logic dout_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   import gyro_pkg::*;

   // Serial half period in system cycles, above the 4-cycle minimum of the synchronisers
   localparam int HALF = 6;

   // Idle bus: deselected, clock parked high for mode 3
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      din = 1'b0;
   end

   // One 16-bit frame, MSB first; reply bit taken just before each rising clock
   task automatic xfer(input word_t tx, output word_t rx);
      int i;
      @(negedge clk);
      cs_n <= 1'b0;
      repeat (HALF) @(negedge clk);
      for (i = 15; i >= 0; i--) begin
         sclk <= 1'b0;
         din <= tx[i];
         repeat (HALF) @(negedge clk);
         // A pin the device does not drive is not trusted
         rx[i] = dout_oe ? dout : 1'bx;
         sclk <= 1'b1;
         repeat (HALF) @(negedge clk);
      end
      cs_n <= 1'b1;
      // Released data line shows the inverse of its last bit
      din <= ~tx[0];
      repeat (HALF) @(negedge clk);
   endtask

   // Read one register by byte address; the reply comes in the following frame
   task automatic read_reg(input logic [6:0] addr, output word_t val);
      word_t dummy;
      xfer({1'b0, addr, 8'h00}, dummy);
      xfer(16'h0000, val);
   endtask
endmodule // spi_host_model

// ### bench/tb_gyro_rate_regs.sv
// Self-checking bench for the rotation output register block
`include "gyro_params.svh"
module tb_gyro_rate_regs;
   timeunit 1ns;
   timeprecision 1ps;
   import gyro_pkg::*;

   // Short internal tick keeps the run brief
   localparam int TICK = 20;
   logic CLK_SYS = 1'b0;
   logic ARST_N = 1'b0;
   sample_t SAMPLE_DATA = '0;
   logic SAMPLE_VALID = 1'b0;
   logic SAMPLE_READY;
   logic [1:0] MISC_SYNC_MODE = 2'h0;
   word_t DECIMATION_SETTING = 16'h0000;
   logic EXT_SYNC = 1'b0;
   logic SPI_SCLK, SPI_CS_N, SPI_DIN, SPI_DOUT, SPI_DOUT_OE;
   int n_mismatch = 0;
   int tests_run = 0;
   sample_t s; // Last sample offered
   int sum [3]; // Window sums of high words per axis
   word_t got;
   word_t prev;
   int m;
   int t;

   // 25 MHz system clock
   always #20 CLK_SYS = ~CLK_SYS;

   gyro_rate_regs #(.TICK_CYCLES(TICK), .FIFO_DEPTH(32)) gyro_rate_regs_inst (
      .CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .SAMPLE_DATA(SAMPLE_DATA), .SAMPLE_VALID(SAMPLE_VALID),
      .SAMPLE_READY(SAMPLE_READY), .MISC_SYNC_MODE(MISC_SYNC_MODE), .DECIMATION_SETTING(DECIMATION_SETTING),
      .EXT_SYNC(EXT_SYNC), .SPI_SCLK(SPI_SCLK), .SPI_CS_N(SPI_CS_N), .SPI_DIN(SPI_DIN),
      .SPI_DOUT(SPI_DOUT), .SPI_DOUT_OE(SPI_DOUT_OE));

   spi_host_model spi_host_model_inst (
      .clk(CLK_SYS), .sclk(SPI_SCLK), .cs_n(SPI_CS_N), .din(SPI_DIN), .dout(SPI_DOUT),
      .dout_oe(SPI_DOUT_OE));

   // Counts, verdict and end of run
   task automatic tally_and_finish();
      $display("counts: %0d compared, %0d mismatched", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Four-state compare of one word
   task automatic chk(input string what, input word_t exp, input word_t seen);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Offer one sample, bounded wait for room; valid stays up for back-to-back use
   task automatic push(input sample_t d);
      int k;
      int a;
      s = d;
      for (a = 0; a < 3; a++) sum[a] += $signed(d[32*a+16 +: 16]);
      SAMPLE_DATA = d;
      SAMPLE_VALID = 1'b1;
      k = 0;
      while (SAMPLE_READY !== 1'b1 && k < 5000) begin
         @(negedge CLK_SYS);
         k++;
      end
      if (k == 5000) begin
         n_mismatch++;
         tally_and_finish();
      end
      @(negedge CLK_SYS);
   endtask

   // Average over the window, truncated toward zero
   function automatic word_t exp_step(input int total, input int n);
      return word_t'(total / n);
   endfunction

   // Random sample of three axes
   function automatic sample_t rnd();
      return {$urandom, $urandom, $urandom};
   endfunction

   // Read back every word of every axis and compare
   task automatic check_all(input int n_win);
      int a;
      word_t lo; // Low word kept for the 20-bit view
      for (a = 0; a < 3; a++) begin
         spi_host_model_inst.read_reg(7'(`RATE_X_LOW_ADDR + 4 * a), got);
         lo = got;
         chk("low word", s[32*a +: 16], got);
         spi_host_model_inst.read_reg(7'(`RATE_X_HIGH_ADDR + 4 * a), got);
         chk("high word", s[32*a+16 +: 16], got);
         // Reader keeps N = 20 bits, LSB weighs scale over 16; bottom 16 of that view
         chk("20-bit rate tail", s[32*a+12 +: 16], {got[11:0], lo[15:12]});
         spi_host_model_inst.read_reg(7'(`RATE_X_HIGH_ADDR + 4 * a + 1), got);
         chk("upper byte", {8'h00, s[32*a+24 +: 8]}, got);
         spi_host_model_inst.read_reg(7'(`ANGLE_STEP_X_ADDR + 2 * a), got);
         chk("angle step", exp_step(sum[a], n_win), got);
      end
   endtask

   // External sample clock edge, then room for the divide
   task automatic ext_edge();
      EXT_SYNC = 1'b1;
      repeat (6) @(negedge CLK_SYS);
      EXT_SYNC = 1'b0;
      repeat (60) @(negedge CLK_SYS);
   endtask

   // Main sequence
   initial begin
      void'($urandom(32'h93D7));
      repeat (8) @(posedge CLK_SYS);
      @(negedge CLK_SYS);
      ARST_N = 1'b1;
      repeat (4) @(negedge CLK_SYS);
      // Reset values and an unmapped place
      s = '0;
      sum = '{0, 0, 0};
      check_all(1);
      spi_host_model_inst.read_reg(7'h30, got);
      chk("unmapped", 16'h0000, got);
      $display("test reset done");
      // Single-sample windows: zero, full scale corners, then random
      for (t = 0; t < 4; t++) begin
         sum = '{0, 0, 0};
         push(t == 0 ? '0 : t == 1 ? {16'hB1E0, 16'h0001, 16'h4E20, 16'hFFFF, 16'h8000, 16'h7FFF} : rnd());
         SAMPLE_VALID = 1'b0;
         repeat (TICK + 40) @(negedge CLK_SYS);
         check_all(1);
      end
      // A write frame between a read and its reply must not move the address
      spi_host_model_inst.xfer({1'b0, `RATE_X_LOW_ADDR, 8'h00}, got);
      spi_host_model_inst.xfer(16'h8655, got);
      chk("reply across write", s[15:0], got);
      spi_host_model_inst.xfer(16'h0000, got);
      chk("write ignored", s[15:0], got);
      $display("test single done");
      // Decimation window of four samples, back to back
      DECIMATION_SETTING = 16'h0003;
      sum = '{0, 0, 0};
      repeat (4) push(rnd());
      SAMPLE_VALID = 1'b0;
      repeat (4 * TICK + 80) @(negedge CLK_SYS);
      check_all(4);
      $display("test decimation done");
      // External sample clock: internal ticks must not pop
      DECIMATION_SETTING = 16'h0000;
      for (m = 1; m < 4; m++) begin
         MISC_SYNC_MODE = 2'(m);
         prev = s[16 +: 16];
         sum = '{0, 0, 0};
         push(rnd());
         SAMPLE_VALID = 1'b0;
         repeat (3 * TICK + 40) @(negedge CLK_SYS);
         spi_host_model_inst.read_reg(`RATE_X_HIGH_ADDR, got);
         chk("held without sync", prev, got);
         ext_edge();
         check_all(1);
      end
      $display("test external done");
      // Fill the buffer until refused, then drain it by external edges
      repeat (32) push(rnd());
      chk("ready when full", 16'h0000, {15'h0000, SAMPLE_READY});
      SAMPLE_VALID = 1'b0;
      repeat (32) ext_edge();
      chk("ready when drained", 16'h0001, {15'h0000, SAMPLE_READY});
      for (t = 0; t < 3; t++) sum[t] = $signed(s[32*t+16 +: 16]);
      check_all(1);
      $display("test buffer done");
      tally_and_finish();
   end
endmodule // tb_gyro_rate_regs
